// ### design/gcm_defs.vh
// Constants for the remote message and common command handler
`ifndef GCM_DEFS_VH
`define GCM_DEFS_VH

// ==================================================
// Input buffer geometry
`define GCM_BUF_AW 10
`define GCM_BUF_DEPTH 11'h400
`define GCM_BUF_W 9

// ==================================================
// Character codes
`define GCM_CH_LF 8'h0A
`define GCM_CH_SP 8'h20
`define GCM_CH_STAR 8'h2A
`define GCM_CH_COLON 8'h3A
`define GCM_CH_SEMI 8'h3B
`define GCM_CH_QUERY 8'h3F
`define GCM_CH_0 8'h30
`define GCM_CH_9 8'h39
`define GCM_CH_UA 8'h41
`define GCM_CH_UZ 8'h5A
`define GCM_CH_LA 8'h61
`define GCM_CH_LZ 8'h7A
`define GCM_CASE_OFS 8'h20

// ==================================================
// Common command keys (three letters after the asterisk)
`define GCM_K_CLS 24'h434C53
`define GCM_K_ESE 24'h455345
`define GCM_K_ESR 24'h455352
`define GCM_K_IDN 24'h49444E
`define GCM_K_OPC 24'h4F5043
`define GCM_K_OPT 24'h4F5054
`define GCM_K_RCL 24'h52434C
`define GCM_K_RST 24'h525354
`define GCM_K_SAV 24'h534156
`define GCM_K_SRE 24'h535245
`define GCM_K_STB 24'h535442
`define GCM_K_TRG 24'h545247
`define GCM_K_TST 24'h545354
`define GCM_K_WAI 24'h574149

// ==================================================
// Status bit positions
`define GCM_ESR_OPC 0
`define GCM_ESR_CME 5
`define GCM_STB_MAV 4
`define GCM_STB_ESB 5
`define GCM_STB_MSS 6

// ==================================================
// Keyword packing and identification answer
`define GCM_KEY_MAX 3'h4
`define GCM_IDN_LEN 5'h0D
// Identification string value is arbitrary
`define GCM_IDN_STR "DEV,LCR0,0,10"

`endif

// ### design/gcm_mem.v
// Input buffer storage with registered read data
`timescale 1ns/1ns
`include "gcm_defs.vh"

module gcm_mem (
    // Clock
    input wire mclk_in,
    // Write port
    input wire wr_en_in,
    input wire [`GCM_BUF_AW-1:0] wr_addr_in,
    input wire [`GCM_BUF_W-1:0] wr_data_in,
    // Read port
    input wire rd_en_in,
    input wire [`GCM_BUF_AW-1:0] rd_addr_in,
    output reg [`GCM_BUF_W-1:0] rd_data_out
);

reg [`GCM_BUF_W-1:0] mem [0:(1<<`GCM_BUF_AW)-1];

always @(posedge mclk_in) begin
    if (wr_en_in) begin
        mem[wr_addr_in] <= wr_data_in;
    end
    if (rd_en_in) begin
        rd_data_out <= mem[rd_addr_in];
    end
end

endmodule // gcm_mem

// ### design/gcm_handler.v
// Remote interface message and common command handler
// Summary of operation
// R1: Interface clear drops talker and listener addressing
// R2: Device clear flushes input, abandons interpretation
// R3: Device clear empties output, clears MAV bit
// R4: Device clear cancels pending WAI/OPC waits
// R5: Device clear releases READ? trigger wait
// R6: Local lockout blocks front panel local request
// R7: Go to local selects local state
// R8: Group trigger acts exactly like TRG
// R9: Short keyword form accepted, long tail ignored
// R10: Implicit keywords may be absent from header
// R11: Alternative keywords accepted via numeric suffix
// R12: ESE writes enable, ESE? returns it
// R13: ESR? returns event status register
// R14: OPC sets bit when idle, OPC? answers 1
// R15: IDN? returns identification string
// R16: SAV stores, RCL restores named slot
// R17: RST resets device settings
// R18: SRE writes enable, SRE? returns it
// R19: STB? returns the status byte
// R20: TRG measures only if bus-armed, then reads
// R21: TST? returns self-test result, 0 good
// R22: WAI holds later commands until idle
// R23: Controller ends messages with LF/EOI
// R24: Bad command flags error, skips to terminator
// R25: 1K byte input buffer, strict arrival order
// R26: CLS clears event status, keeps enables
`timescale 1ns/1ns
`include "gcm_defs.vh"

module gcm_handler (
    // Clock and reset
    input wire mclk_in,
    input wire rst_n_in,
    // Received data bytes
    input wire [7:0] rx_data_in,
    input wire rx_eoi_in,
    input wire rx_valid_in,
    output wire rx_ready_out,
    // Response bytes
    output wire [7:0] tx_data_out,
    output wire tx_valid_out,
    input wire tx_ready_in,
    // Interface messages
    input wire ifc_in,
    input wire dcl_in,
    input wire llo_in,
    input wire gtl_in,
    input wire get_in,
    input wire ren_in,
    input wire lad_in,
    input wire tad_in,
    input wire unl_in,
    input wire local_key_in,
    output wire listen_out,
    output wire talk_out,
    output wire remote_out,
    output wire lockout_out,
    output wire dev_clear_out,
    // Measurement side
    input wire op_busy_in,
    input wire trig_src_bus_in,
    input wire trig_armed_in,
    input wire meas_done_in,
    input wire [7:0] tst_result_in,
    output reg meas_trig_out,
    output reg fetch_out,
    output reg rst_cmd_out,
    output reg sav_out,
    output reg rcl_out,
    output reg [7:0] slot_out,
    output reg clr_status_out,
    // Status
    input wire [7:0] esr_set_in,
    input wire [7:0] stb_ext_in,
    output wire [7:0] stb_out,
    output wire srq_out,
    output reg cmd_err_out,
    // Subsystem header tokens
    output reg kw_valid_out,
    output reg [31:0] kw_out,
    output reg [3:0] kw_suffix_out,
    output reg [2:0] kw_depth_out,
    output reg kw_last_out,
    output reg kw_query_out,
    output reg [7:0] param_out
);

localparam [6:0] S_IDLE = 7'h01, S_HDR = 7'h02, S_PARAM = 7'h04, S_SKIP = 7'h08,
    S_EXEC = 7'h10, S_WAIT = 7'h20, S_RESP = 7'h40;
localparam [8*`GCM_IDN_LEN-1:0] IDN = `GCM_IDN_STR;

// ==================================================
// Response character generator
function [7:0] resp_char;
    input idn;
    input [7:0] v;
    input [4:0] i;
    reg [7:0] h, t, o;
    begin
        h = v / 8'd100;
        t = (v / 8'd10) % 8'd10;
        o = v % 8'd10;
        resp_char = `GCM_CH_LF;
        if (idn) begin
            if (i < `GCM_IDN_LEN) resp_char = IDN[8*(`GCM_IDN_LEN-1-i) +: 8];
        end else if (v >= 8'd100) begin
            if (i == 5'h0) resp_char = `GCM_CH_0 + h;
            else if (i == 5'h1) resp_char = `GCM_CH_0 + t;
            else if (i == 5'h2) resp_char = `GCM_CH_0 + o;
        end else if (v >= 8'd10) begin
            if (i == 5'h0) resp_char = `GCM_CH_0 + t;
            else if (i == 5'h1) resp_char = `GCM_CH_0 + o;
        end else if (i == 5'h0) begin
            resp_char = `GCM_CH_0 + o;
        end
    end
endfunction

function [4:0] resp_last;
    input idn;
    input [7:0] v;
    begin
        if (idn) resp_last = `GCM_IDN_LEN;
        else if (v >= 8'd100) resp_last = 5'h3;
        else if (v >= 8'd10) resp_last = 5'h2;
        else resp_last = 5'h1;
    end
endfunction

// ==================================================
// Bus interface state
reg listen_q, talk_q, remote_q, lockout_q;

always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        listen_q <= 1'b0;
        talk_q <= 1'b0;
        remote_q <= 1'b0;
        lockout_q <= 1'b0;
    end else begin
        if (ifc_in) begin
            listen_q <= 1'b0; // R1
            talk_q <= 1'b0; // R1
        end else if (lad_in) begin
            listen_q <= 1'b1;
            talk_q <= 1'b0;
        end else if (tad_in) begin
            talk_q <= 1'b1;
            listen_q <= 1'b0;
        end else if (unl_in) begin
            listen_q <= 1'b0;
        end
        if (!ren_in) begin
            remote_q <= 1'b0;
            lockout_q <= 1'b0;
        end else begin
            if (llo_in) lockout_q <= 1'b1;
            if (lad_in) remote_q <= 1'b1;
            else if (gtl_in) remote_q <= 1'b0; // R7
            else if (local_key_in && !lockout_q) remote_q <= 1'b0; // R6
        end
    end
end

assign listen_out = listen_q;
assign talk_out = talk_q;
assign remote_out = remote_q;
assign lockout_out = lockout_q;
assign dev_clear_out = dcl_in; // R5

// ==================================================
// Input buffer
reg [`GCM_BUF_AW-1:0] wr_ptr_q, rd_ptr_q;
reg [`GCM_BUF_AW:0] cnt_q;
reg rd_pend_q;
reg [6:0] st_q;
wire [`GCM_BUF_W-1:0] rd_word;
wire wr_en = rx_valid_in && rx_ready_out;
wire parse_st = (st_q & (S_IDLE | S_HDR | S_PARAM | S_SKIP)) != 7'h0;
wire rd_en = parse_st && (cnt_q != 11'h0) && !rd_pend_q && !dcl_in;

assign rx_ready_out = (cnt_q != `GCM_BUF_DEPTH) && !dcl_in; // R25

gcm_mem u_mem (
    .mclk_in(mclk_in),
    .wr_en_in(wr_en),
    .wr_addr_in(wr_ptr_q),
    .wr_data_in({rx_eoi_in, rx_data_in}),
    .rd_en_in(rd_en),
    .rd_addr_in(rd_ptr_q),
    .rd_data_out(rd_word)
);

always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        wr_ptr_q <= {`GCM_BUF_AW{1'b0}};
        rd_ptr_q <= {`GCM_BUF_AW{1'b0}};
        cnt_q <= 11'h0;
        rd_pend_q <= 1'b0;
    end else if (dcl_in) begin
        wr_ptr_q <= {`GCM_BUF_AW{1'b0}}; // R2
        rd_ptr_q <= {`GCM_BUF_AW{1'b0}}; // R2
        cnt_q <= 11'h0;
        rd_pend_q <= 1'b0;
    end else begin
        rd_pend_q <= rd_en;
        if (wr_en) wr_ptr_q <= wr_ptr_q + 1'b1; // R25
        if (rd_en) rd_ptr_q <= rd_ptr_q + 1'b1; // R25
        cnt_q <= cnt_q + {10'h0, wr_en} - {10'h0, rd_en};
    end
end

// ==================================================
// Character classes
wire [7:0] raw = rd_word[7:0];
wire is_low = raw >= `GCM_CH_LA && raw <= `GCM_CH_LZ;
wire [7:0] ch = is_low ? raw - `GCM_CASE_OFS : raw;
wire is_let = ch >= `GCM_CH_UA && ch <= `GCM_CH_UZ;
wire is_dig = ch >= `GCM_CH_0 && ch <= `GCM_CH_9;
wire [7:0] dig = ch - `GCM_CH_0;
wire msg_end = ch == `GCM_CH_LF || rd_word[8]; // R23
wire unit_end = msg_end || ch == `GCM_CH_SEMI;

// ==================================================
// Status registers
reg [7:0] esr_q, ese_q, sre_q;
wire mav = st_q == S_RESP; // R3
wire esb = |(esr_q & ese_q);
wire [7:0] stb_base = {stb_ext_in[7], 1'b0, esb, mav, stb_ext_in[3:0]};
wire mss = |(stb_base & sre_q);
assign stb_out = stb_base | ({7'h0, mss} << `GCM_STB_MSS);
assign srq_out = mss;

// ==================================================
// Parser and executor
reg [31:0] key_q;
reg [2:0] klen_q, depth_q;
reg [3:0] suf_q;
reg [7:0] par_q, rval_q;
reg com_q, qry_q, end_q, opc_pend_q, opc_resp_q, trg_pend_q, ridn_q;
reg [4:0] ridx_q;
reg [7:0] tx_q;
reg esr_clr, opc_set, trig;

assign tx_data_out = tx_q;
assign tx_valid_out = mav;

always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        st_q <= S_IDLE;
        key_q <= 32'h0;
        klen_q <= 3'h0;
        depth_q <= 3'h0;
        suf_q <= 4'h0;
        par_q <= 8'h0;
        rval_q <= 8'h0;
        com_q <= 1'b0;
        qry_q <= 1'b0;
        end_q <= 1'b0;
        opc_pend_q <= 1'b0;
        opc_resp_q <= 1'b0;
        ridn_q <= 1'b0;
        ridx_q <= 5'h0;
        tx_q <= 8'h0;
        ese_q <= 8'h0;
        sre_q <= 8'h0;
        rst_cmd_out <= 1'b0;
        sav_out <= 1'b0;
        rcl_out <= 1'b0;
        slot_out <= 8'h0;
        clr_status_out <= 1'b0;
        cmd_err_out <= 1'b0;
        kw_valid_out <= 1'b0;
        kw_out <= 32'h0;
        kw_suffix_out <= 4'h0;
        kw_depth_out <= 3'h0;
        kw_last_out <= 1'b0;
        kw_query_out <= 1'b0;
        param_out <= 8'h0;
        esr_clr <= 1'b0;
        opc_set <= 1'b0;
        trig <= 1'b0;
    end else begin
        rst_cmd_out <= 1'b0;
        sav_out <= 1'b0;
        rcl_out <= 1'b0;
        clr_status_out <= 1'b0;
        cmd_err_out <= 1'b0;
        kw_valid_out <= 1'b0;
        esr_clr <= 1'b0;
        opc_set <= 1'b0;
        trig <= 1'b0;
        if (opc_pend_q && !op_busy_in) begin
            opc_pend_q <= 1'b0; // R14
            opc_set <= 1'b1; // R14
        end
        if (dcl_in) begin
            st_q <= S_IDLE; // R2
            opc_pend_q <= 1'b0; // R4
            opc_resp_q <= 1'b0; // R4
        end else begin
            case (st_q)
            S_IDLE, S_HDR, S_PARAM, S_SKIP: begin
                if (rd_pend_q) begin
                    if (st_q == S_SKIP) begin
                        if (msg_end) st_q <= S_IDLE; // R24
                    end else if (st_q == S_IDLE) begin
                        key_q <= 32'h0;
                        klen_q <= 3'h0;
                        depth_q <= 3'h0;
                        suf_q <= 4'h0;
                        par_q <= 8'h0;
                        qry_q <= 1'b0;
                        end_q <= msg_end;
                        com_q <= ch == `GCM_CH_STAR;
                        if (ch == `GCM_CH_STAR || ch == `GCM_CH_COLON) begin
                            st_q <= S_HDR;
                        end else if (is_let) begin
                            key_q <= {24'h0, ch};
                            klen_q <= 3'h1;
                            st_q <= S_HDR;
                        end else if (ch != `GCM_CH_SP && !unit_end) begin
                            cmd_err_out <= 1'b1; // R24
                            st_q <= S_SKIP;
                        end
                    end else begin
                        end_q <= msg_end;
                        if (st_q == S_HDR && is_let && klen_q < `GCM_KEY_MAX) begin
                            key_q <= {key_q[23:0], ch}; // R9
                            klen_q <= klen_q + 3'h1;
                        end else if (st_q == S_HDR && is_dig) begin
                            suf_q <= suf_q * 4'hA + dig[3:0]; // R11
                        end else if (st_q == S_HDR && ch == `GCM_CH_QUERY) begin
                            qry_q <= 1'b1;
                        end else if (st_q == S_HDR && ch == `GCM_CH_COLON && !com_q) begin
                            kw_valid_out <= 1'b1;
                            kw_out <= key_q;
                            kw_suffix_out <= suf_q;
                            kw_depth_out <= depth_q;
                            kw_last_out <= 1'b0;
                            kw_query_out <= 1'b0;
                            depth_q <= depth_q + 3'h1;
                            key_q <= 32'h0;
                            klen_q <= 3'h0;
                            suf_q <= 4'h0;
                        end else if (ch == `GCM_CH_SP) begin
                            st_q <= S_PARAM;
                        end else if (st_q == S_PARAM && is_dig) begin
                            par_q <= par_q * 8'hA + dig;
                        end
                        if (unit_end) st_q <= S_EXEC;
                    end
                end
            end
            S_EXEC: begin
                st_q <= S_IDLE;
                ridn_q <= 1'b0;
                ridx_q <= 5'h0;
                if (!com_q) begin
                    // Header may stop early; depth tells the tree which levels are implied
                    kw_valid_out <= 1'b1; // R10
                    kw_out <= key_q;
                    kw_suffix_out <= suf_q;
                    kw_depth_out <= depth_q;
                    kw_last_out <= 1'b1;
                    kw_query_out <= qry_q;
                    param_out <= par_q;
                end else begin
                    case ({qry_q, key_q[23:0]})
                    {1'b0, `GCM_K_CLS}: begin
                        esr_clr <= 1'b1; // R26
                        opc_pend_q <= 1'b0;
                        clr_status_out <= 1'b1; // R26
                    end
                    {1'b0, `GCM_K_ESE}: ese_q <= par_q; // R12
                    {1'b1, `GCM_K_ESE}: begin
                        rval_q <= ese_q; // R12
                        tx_q <= resp_char(1'b0, ese_q, 5'h0);
                        st_q <= S_RESP;
                    end
                    {1'b1, `GCM_K_ESR}: begin
                        rval_q <= esr_q; // R13
                        tx_q <= resp_char(1'b0, esr_q, 5'h0);
                        esr_clr <= 1'b1;
                        st_q <= S_RESP;
                    end
                    {1'b1, `GCM_K_IDN}: begin
                        ridn_q <= 1'b1; // R15
                        tx_q <= resp_char(1'b1, 8'h0, 5'h0);
                        st_q <= S_RESP;
                    end
                    {1'b0, `GCM_K_OPC}: opc_pend_q <= 1'b1; // R14
                    {1'b1, `GCM_K_OPC}: begin
                        opc_resp_q <= 1'b1; // R14
                        st_q <= S_WAIT;
                    end
                    {1'b1, `GCM_K_OPT}: begin
                        rval_q <= 8'h0;
                        tx_q <= resp_char(1'b0, 8'h0, 5'h0);
                        st_q <= S_RESP;
                    end
                    {1'b0, `GCM_K_RCL}: begin
                        rcl_out <= 1'b1; // R16
                        slot_out <= par_q;
                    end
                    {1'b0, `GCM_K_SAV}: begin
                        sav_out <= 1'b1; // R16
                        slot_out <= par_q;
                    end
                    {1'b0, `GCM_K_RST}: begin
                        rst_cmd_out <= 1'b1; // R17
                        opc_pend_q <= 1'b0;
                    end
                    {1'b0, `GCM_K_SRE}: sre_q <= par_q; // R18
                    {1'b1, `GCM_K_SRE}: begin
                        rval_q <= sre_q; // R18
                        tx_q <= resp_char(1'b0, sre_q, 5'h0);
                        st_q <= S_RESP;
                    end
                    {1'b1, `GCM_K_STB}: begin
                        rval_q <= stb_out; // R19
                        tx_q <= resp_char(1'b0, stb_out, 5'h0);
                        st_q <= S_RESP;
                    end
                    {1'b0, `GCM_K_TRG}: trig <= 1'b1; // R20
                    {1'b1, `GCM_K_TST}: begin
                        rval_q <= tst_result_in; // R21
                        tx_q <= resp_char(1'b0, tst_result_in, 5'h0);
                        st_q <= S_RESP;
                    end
                    {1'b0, `GCM_K_WAI}: st_q <= S_WAIT; // R22
                    default: begin
                        cmd_err_out <= 1'b1; // R24
                        st_q <= end_q ? S_IDLE : S_SKIP; // R24
                    end
                    endcase
                end
            end
            S_WAIT: begin
                if (!op_busy_in) begin
                    st_q <= S_IDLE; // R22
                    if (opc_resp_q) begin
                        opc_resp_q <= 1'b0;
                        rval_q <= 8'h1; // R14
                        tx_q <= resp_char(1'b0, 8'h1, 5'h0);
                        st_q <= S_RESP;
                    end
                end
            end
            S_RESP: begin
                if (tx_ready_in) begin
                    if (ridx_q == resp_last(ridn_q, rval_q)) begin
                        st_q <= S_IDLE;
                    end else begin
                        ridx_q <= ridx_q + 5'h1;
                        tx_q <= resp_char(ridn_q, rval_q, ridx_q + 5'h1);
                    end
                end
            end
            default: st_q <= S_IDLE;
            endcase
        end
    end
end

// ==================================================
// Event status and trigger
always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        esr_q <= 8'h0;
        trg_pend_q <= 1'b0;
        meas_trig_out <= 1'b0;
        fetch_out <= 1'b0;
    end else begin
        // Events arriving with a clear are kept
        esr_q <= (esr_clr ? 8'h0 : esr_q) | esr_set_in
            | ({7'h0, opc_set} << `GCM_ESR_OPC)
            | ({7'h0, cmd_err_out} << `GCM_ESR_CME); // R24
        meas_trig_out <= 1'b0;
        fetch_out <= 1'b0;
        if (dcl_in) begin
            trg_pend_q <= 1'b0; // R5
        end else if ((trig || get_in) && trig_src_bus_in && trig_armed_in) begin
            meas_trig_out <= 1'b1; // R8 R20
            trg_pend_q <= 1'b1;
        end else if (trg_pend_q && meas_done_in) begin
            fetch_out <= 1'b1; // R20
            trg_pend_q <= 1'b0;
        end
    end
end

endmodule // gcm_handler

// ### test/gcm_monitor.sv
// Checker on the handler ports
`timescale 1ns/1ns
module gcm_monitor (
    // Clock and reset
    input wire mclk_in,
    input wire rst_n_in,
    // Watched inputs
    input wire ifc_in, dcl_in, gtl_in, lad_in, tad_in, get_in, ren_in, local_key_in,
    input wire trig_src_bus_in, trig_armed_in,
    // Watched outputs
    input wire listen_out, talk_out, remote_out, lockout_out, rx_ready_out,
    input wire tx_valid_out, dev_clear_out, meas_trig_out,
    input wire [7:0] stb_out
);
    // ==================================================
    // Port relations
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    AST_IFC: assert property (ifc_in && !lad_in && !tad_in |=> !listen_out && !talk_out)
        else $error("bus clear kept addressing");
    AST_DCL_RDY: assert property (dcl_in |-> !rx_ready_out)
        else $error("input taken during device clear");
    AST_DCL_TX: assert property (dcl_in |=> !tx_valid_out)
        else $error("response survived device clear");
    AST_DCL_MAV: assert property (dcl_in |=> !stb_out[4])
        else $error("message available kept after device clear");
    AST_RD_WAIT: assert property (dcl_in |-> dev_clear_out)
        else $error("trigger wait not released");
    AST_LLO: assert property (remote_out && lockout_out && ren_in && local_key_in && !gtl_in
        |=> remote_out)
        else $error("local key left remote under lockout");
    AST_GTL: assert property (gtl_in && !lad_in |=> !remote_out)
        else $error("go to local ignored");
    AST_GET: assert property (get_in && trig_src_bus_in && trig_armed_in |=> meas_trig_out)
        else $error("group trigger did not trigger");
endmodule // gcm_monitor

bind gcm_handler gcm_monitor u_mon (.*);

// ### test/gcm_host.sv
// Bus controller model: sends program messages and takes responses
`timescale 1ns/1ns
module gcm_host (
    // Handler side
    input wire mclk_in,
    input wire rx_ready_in,
    output logic [7:0] rx_data_out,
    output logic rx_eoi_out,
    output logic rx_valid_out,
    input wire [7:0] tx_data_in,
    input wire tx_valid_in,
    output logic tx_ready_out
);
    string resp = "";
    string ch = " ";
    logic slow = 1'b0;
    int hang = 0;
    initial begin
        rx_data_out = 8'h00;
        rx_eoi_out = 1'b0;
        rx_valid_out = 1'b0;
        tx_ready_out = 1'b1;
    end
    // ==================================================
    // Response taker, stalls every other cycle when slow
    always @(negedge mclk_in) tx_ready_out <= slow ? ~tx_ready_out : 1'b1;
    always @(posedge mclk_in) begin
        if (tx_valid_in && tx_ready_out) begin
            ch[0] = tx_data_in;
            resp = {resp, ch};
        end
    end
    // Bytes held until taken; message closes with line feed and end flag
    task automatic send(input string s);
        int i;
        int n;
        s = {s, "\n"};
        for (i = 0; i < s.len(); i++) begin
            @(negedge mclk_in);
            rx_data_out <= s[i];
            rx_eoi_out <= (i == s.len() - 1);
            rx_valid_out <= 1'b1;
            n = 0;
            while (!rx_ready_in && n < 5000) begin
                @(negedge mclk_in);
                n++;
            end
            if (n >= 5000) hang++;
            @(posedge mclk_in);
        end
        @(negedge mclk_in);
        rx_valid_out <= 1'b0;
        rx_data_out <= ~rx_data_out;
    endtask
endmodule // gcm_host

// ### test/gcm_handler_bench.sv
// Self-checking bench for the message and common command handler
`timescale 1ns/1ns
`include "gcm_defs.vh"
module gcm_handler_bench;
    logic mclk_in = 0, rst_n_in = 0, tx_ready_in, rx_eoi_in, rx_valid_in;
    logic ifc_in = 0, dcl_in = 0, llo_in = 0, gtl_in = 0, get_in = 0, ren_in = 0;
    logic lad_in = 0, tad_in = 0, unl_in = 0, local_key_in = 0, op_busy_in = 0;
    logic trig_src_bus_in = 0, trig_armed_in = 0, meas_done_in = 0;
    logic [7:0] tst_result_in = 0, esr_set_in = 0, stb_ext_in = 0, rx_data_in;
    wire rx_ready_out, tx_valid_out, listen_out, talk_out, remote_out, lockout_out;
    wire dev_clear_out, meas_trig_out, fetch_out, rst_cmd_out, sav_out, rcl_out;
    wire clr_status_out, srq_out, cmd_err_out, kw_valid_out, kw_last_out, kw_query_out;
    wire [7:0] tx_data_out, slot_out, stb_out, param_out;
    wire [31:0] kw_out;
    wire [3:0] kw_suffix_out;
    wire [2:0] kw_depth_out;
    int fail_count = 0, n_compared = 0, ntrig = 0, nfetch = 0, nsav = 0, nrcl = 0, nrst = 0;
    gcm_handler dut (.*);
    gcm_host host (.mclk_in(mclk_in), .rx_ready_in(rx_ready_out), .rx_data_out(rx_data_in),
        .rx_eoi_out(rx_eoi_in), .rx_valid_out(rx_valid_in), .tx_data_in(tx_data_out),
        .tx_valid_in(tx_valid_out), .tx_ready_out(tx_ready_in));
    initial forever #50 mclk_in = ~mclk_in;
    always @(posedge mclk_in) begin
        ntrig += (meas_trig_out === 1'b1);
        nfetch += (fetch_out === 1'b1);
        nsav += (sav_out === 1'b1);
        nrcl += (rcl_out === 1'b1);
        nrst += (rst_cmd_out === 1'b1);
    end
    // ==================================================
    // Shared helpers
    task automatic chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic pulse(ref logic s);
        @(negedge mclk_in) s = 1'b1;
        @(negedge mclk_in) s = 1'b0;
    endtask
    task automatic resp_is(input string e, input string m);
        int n = 0;
        while (host.resp.len() < e.len() && n < 3000) begin
            @(negedge mclk_in);
            n++;
        end
        repeat (20) @(negedge mclk_in);
        chk(host.resp == e, m);
        host.resp = "";
    endtask
    task end_of_test;
        if (fail_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ==================================================
    // Scenarios
    task t_status;
        host.send("*ESE 9");
        host.send("*ESE?");
        resp_is("9\n", "enable readback");
        host.send("*sre 33;*SRE?");
        resp_is("33\n", "request enable readback");
        host.send("*XYZ;*ESE 5");
        host.send("*ESR?");
        resp_is("32\n", "command error bit");
        host.send("*ESE?");
        resp_is("9\n", "rest of bad message not skipped");
        @(negedge mclk_in) esr_set_in = 8'h80;
        @(negedge mclk_in) esr_set_in = 8'h00;
        host.send("*CLS;*ESR?;*SRE?");
        resp_is("0\n33\n", "clear status");
    endtask
    task t_query;
        host.send("*TST?");
        resp_is("0\n", "self test");
        host.slow = 1'b1;
        host.send("*IDN?");
        resp_is({`GCM_IDN_STR, "\n"}, "identification");
        host.slow = 1'b0;
    endtask
    task t_opc;
        op_busy_in = 1'b1;
        host.send("*OPC?");
        resp_is("", "early completion");
        op_busy_in = 1'b0;
        resp_is("1\n", "completion answer");
        op_busy_in = 1'b1;
        host.send("*WAI;*ESE?");
        resp_is("", "wait not held");
        op_busy_in = 1'b0;
        resp_is("9\n", "wait released");
        op_busy_in = 1'b1;
        host.send("*OPC?");
        repeat (20) @(negedge mclk_in);
        pulse(dcl_in);
        op_busy_in = 1'b0;
        resp_is("", "wait survived device clear");
    endtask
    task t_trig;
        trig_src_bus_in = 1'b1;
        trig_armed_in = 1'b1;
        pulse(get_in);
        pulse(meas_done_in);
        @(negedge mclk_in);
        chk(ntrig == 1 && nfetch == 1, "group trigger");
        host.send("*TRG");
        repeat (20) @(negedge mclk_in);
        chk(ntrig == 2, "bus trigger");
        trig_armed_in = 1'b0;
        host.send("*TRG;*SAV 3;*RCL 3;*RST");
        repeat (40) @(negedge mclk_in);
        chk(ntrig == 2, "unarmed trigger");
        chk(nsav == 1 && nrcl == 1 && slot_out === 8'h03, "save recall");
        chk(nrst == 1, "reset command");
    endtask
    task t_if;
        ren_in = 1'b1;
        pulse(lad_in);
        chk(remote_out === 1'b1 && listen_out === 1'b1, "remote on address");
        pulse(llo_in);
        pulse(local_key_in);
        chk(remote_out === 1'b1 && lockout_out === 1'b1, "lockout");
        pulse(gtl_in);
        chk(remote_out === 1'b0, "go to local");
        pulse(tad_in);
        chk(talk_out === 1'b1 && listen_out === 1'b0, "talk address");
        pulse(ifc_in);
        chk(talk_out === 1'b0 && listen_out === 1'b0, "interface clear");
    endtask
    initial begin
        repeat (3) @(negedge mclk_in);
        rst_n_in = 1'b1;
        t_status();
        t_query();
        t_opc();
        t_trig();
        t_if();
        chk(host.hang == 0, "input stalled");
        end_of_test();
    end
    initial begin
        #5000000;
        fail_count++;
        end_of_test();
    end
endmodule // gcm_handler_bench
